/* rtl/serial_ctl2.sv */
// serial port with second control register, audio framing and error events
`timescale 1ns/1ps
`default_nettype none
// Contract
// - sign-extend set: rx words widen with sign bit; clear: zero filled
// - frame error raises error event only when its enable is set
// - rx overflow raises error event only when its enable is set
// - tx underrun raises error event only when its enable is set
// - ignore overflow set: held rx data is kept, new word dropped
// - ignore overflow clear: overflow halts serial operation
// - ignore underrun set: zeros shifted until tx buffer refills
// - ignore underrun clear: underrun halts serial operation
// - audio enable selects codec framing, clear gives plain serial
// - mono sends each word that opens on a left slot in both left and right slots
// - protocol select 00 i2s, 01 left, 10 right, 11 pcm
// - audio enable, mono, protocol fields writable only while module off
// - mono and protocol select act only while audio enable is set
// - unimplemented bits read as zero
module serial_ctl2 #(
    parameter int width = 16
) (
    input wire logic clk, // 50 mhz clock
    input wire logic rst, // sync reset, high
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic sck, // link bit clock from peer
    input wire logic frame, // frame / word select from peer
    input wire logic sdi, // serial data in
    output logic sdo, // serial data out
    output logic irq // error interrupt level
);
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic on;
        logic halted;
        logic [31:0] ctrl2;
        logic [2:0] status;
        logic [2:0] mask;
        logic [2:0] sck_s;
        logic [2:0] frm_s;
        logic [1:0] sdi_s;
        logic [width-1:0] rx_sh;
        logic [width-1:0] rx_hold;
        logic rx_full;
        logic [width-1:0] tx_sh;
        logic [width-1:0] tx_buf;
        logic tx_full;
        logic [7:0] bitcnt;
        logic right_slot;
        logic sdo;
        logic irq;
    } state_type;

    state_type q_r, q_nxt;

    logic aud, mono, sck_rise, sck_fall, frm_edge, word_done, frm_err;
    logic [1:0] amode;
    logic [31:0] rx_word;
    logic [31:0] wmask;

    always_comb begin
        q_nxt = q_r;
        aud = q_r.ctrl2[serial_ctl2_pkg::aud_en_bit];
        mono = aud & q_r.ctrl2[serial_ctl2_pkg::mono_bit];
        // plain serial ignores the audio fields and starts on the word's first edge
        amode = aud ? q_r.ctrl2[serial_ctl2_pkg::mod_lo_bit +: 2] :
            serial_ctl2_pkg::mode_left;
        wmask = {{8{q_r.wstrb[3]}}, {8{q_r.wstrb[2]}}, {8{q_r.wstrb[1]}}, {8{q_r.wstrb[0]}}};
        // sign extension of held receive word
        if (q_r.ctrl2[serial_ctl2_pkg::sign_ext_bit]) begin
            rx_word = {{(32 - width){q_r.rx_hold[width-1]}}, q_r.rx_hold};
        end else begin
            rx_word = {{(32 - width){1'b0}}, q_r.rx_hold};
        end
        // link sampling, two flops before use
        q_nxt.sck_s = {q_r.sck_s[1:0], sck};
        q_nxt.frm_s = {q_r.frm_s[1:0], frame};
        q_nxt.sdi_s = {q_r.sdi_s[0], sdi};
        sck_rise = q_r.sck_s[1] & ~q_r.sck_s[2];
        sck_fall = ~q_r.sck_s[1] & q_r.sck_s[2];
        frm_edge = q_r.frm_s[1] ^ q_r.frm_s[2];
        word_done = 1'b0;
        frm_err = 1'b0;
        if (q_r.on && !q_r.halted) begin
            // word boundary: frame edge in audio mode starts a slot
            if (sck_fall && frm_edge) begin
                if (aud && q_r.bitcnt != 8'(width) && q_r.bitcnt != 8'h00) begin
                    frm_err = 1'b1;
                end
                q_nxt.bitcnt = 8'h00;
                q_nxt.right_slot = aud ? q_r.frm_s[1] : 1'b0;
                // pcm and left justified start immediately; i2s waits one bit
                if (!q_r.tx_full) begin
                    q_nxt.tx_sh = '0;
                    if (!q_r.ctrl2[serial_ctl2_pkg::ign_tur_bit]) begin
                        q_nxt.halted = 1'b1;
                    end
                    if (q_r.ctrl2[serial_ctl2_pkg::tur_en_bit]) begin
                        q_nxt.status[2] = 1'b1;
                    end
                end else begin
                    q_nxt.tx_sh = q_r.tx_buf;
                    if (!(mono && !q_r.frm_s[1])) begin
                        q_nxt.tx_full = 1'b0;
                    end
                end
                if (amode == serial_ctl2_pkg::mode_i2s ||
                    amode == serial_ctl2_pkg::mode_right) begin
                    q_nxt.sdo = 1'b0;
                end else begin
                    q_nxt.sdo = q_nxt.tx_sh[width-1];
                    q_nxt.tx_sh = {q_nxt.tx_sh[width-2:0], 1'b0};
                end
            end else if (sck_fall) begin
                q_nxt.sdo = q_r.tx_sh[width-1];
                q_nxt.tx_sh = {q_r.tx_sh[width-2:0], 1'b0};
            end
            if (sck_rise && q_r.bitcnt != 8'(width)) begin
                q_nxt.rx_sh = {q_r.rx_sh[width-2:0], q_r.sdi_s[1]};
                q_nxt.bitcnt = q_r.bitcnt + 8'h01;
                word_done = (q_r.bitcnt == 8'(width - 1));
            end
            if (word_done) begin
                if (!q_r.rx_full) begin
                    q_nxt.rx_hold = q_nxt.rx_sh;
                    q_nxt.rx_full = 1'b1;
                end else begin
                    // held word is kept either way; the new one is lost
                    if (!q_r.ctrl2[serial_ctl2_pkg::ign_rov_bit]) begin
                        q_nxt.halted = 1'b1;
                    end
                    q_nxt.status[1] = q_r.ctrl2[serial_ctl2_pkg::rov_en_bit] | q_r.status[1];
                end
            end
        end
        if (frm_err && q_r.ctrl2[serial_ctl2_pkg::frm_en_bit]) begin
            q_nxt.status[0] = 1'b1;
        end
        // axi write path
        if (s_axi_awvalid && q_r.awready) begin
            q_nxt.aw_got = 1'b1;
            q_nxt.awaddr = s_axi_awaddr;
            q_nxt.awready = 1'b0;
        end
        if (s_axi_wvalid && q_r.wready) begin
            q_nxt.w_got = 1'b1;
            q_nxt.wdata = s_axi_wdata;
            q_nxt.wstrb = s_axi_wstrb;
            q_nxt.wready = 1'b0;
        end
        if (q_r.aw_got && q_r.w_got && !q_r.bvalid) begin
            q_nxt.aw_got = 1'b0;
            q_nxt.w_got = 1'b0;
            q_nxt.bvalid = 1'b1;
            q_nxt.bresp = serial_ctl2_pkg::resp_okay;
            case (q_r.awaddr)
                serial_ctl2_pkg::ctrl1_addr: begin
                    if (q_r.wstrb[0]) begin
                        q_nxt.on = q_r.wdata[serial_ctl2_pkg::on_bit];
                        if (!q_r.wdata[serial_ctl2_pkg::on_bit]) begin
                            q_nxt.halted = 1'b0;
                            q_nxt.bitcnt = 8'h00;
                        end
                    end
                end
                serial_ctl2_pkg::ctrl2_addr: begin
                    // locked fields hold while the module is on
                    q_nxt.ctrl2 = (q_r.ctrl2 & ~(wmask & serial_ctl2_pkg::ctrl2_mask &
                        ~(q_r.on ? serial_ctl2_pkg::ctrl2_locked : 32'h0))) |
                        (q_r.wdata & wmask & serial_ctl2_pkg::ctrl2_mask &
                        ~(q_r.on ? serial_ctl2_pkg::ctrl2_locked : 32'h0));
                end
                serial_ctl2_pkg::status_addr: begin
                    // new events this cycle win over the clear
                    if (q_r.wstrb[0]) begin
                        q_nxt.status = q_nxt.status & ~(q_r.wdata[2:0] &
                            ~(q_nxt.status & ~q_r.status));
                    end
                end
                serial_ctl2_pkg::mask_addr: begin
                    if (q_r.wstrb[0]) begin
                        q_nxt.mask = q_r.wdata[2:0] & serial_ctl2_pkg::irq_bits;
                    end
                end
                serial_ctl2_pkg::txdata_addr: begin
                    q_nxt.tx_buf = q_r.wdata[width-1:0];
                    q_nxt.tx_full = 1'b1;
                end
                default: begin
                    q_nxt.bresp = serial_ctl2_pkg::resp_slverr;
                end
            endcase
        end
        if (q_r.bvalid && s_axi_bready) begin
            q_nxt.bvalid = 1'b0;
            q_nxt.awready = 1'b1;
            q_nxt.wready = 1'b1;
        end
        // axi read path
        if (s_axi_arvalid && q_r.arready) begin
            q_nxt.arready = 1'b0;
            q_nxt.rvalid = 1'b1;
            q_nxt.rresp = serial_ctl2_pkg::resp_okay;
            case (s_axi_araddr)
                serial_ctl2_pkg::ctrl1_addr: q_nxt.rdata = {30'h0, q_r.halted, q_r.on};
                serial_ctl2_pkg::ctrl2_addr: begin
                    q_nxt.rdata = q_r.ctrl2 & serial_ctl2_pkg::ctrl2_mask;
                end
                serial_ctl2_pkg::status_addr: q_nxt.rdata = {29'h0, q_r.status};
                serial_ctl2_pkg::mask_addr: q_nxt.rdata = {29'h0, q_r.mask};
                serial_ctl2_pkg::rxdata_addr: begin
                    q_nxt.rdata = rx_word;
                    q_nxt.rx_full = 1'b0;
                end
                default: begin
                    q_nxt.rdata = 32'h0;
                    q_nxt.rresp = serial_ctl2_pkg::resp_slverr;
                end
            endcase
        end
        if (q_r.rvalid && s_axi_rready) begin
            q_nxt.rvalid = 1'b0;
            q_nxt.arready = 1'b1;
        end
        q_nxt.irq = |(q_nxt.status & q_nxt.mask);
        if (rst) begin
            q_nxt = '0;
            q_nxt.ctrl2 = serial_ctl2_pkg::ctrl2_reset;
            q_nxt.awready = 1'b1;
            q_nxt.wready = 1'b1;
            q_nxt.arready = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        q_r <= q_nxt;
    end

    assign s_axi_awready = q_r.awready;
    assign s_axi_wready = q_r.wready;
    assign s_axi_bvalid = q_r.bvalid;
    assign s_axi_bresp = q_r.bresp;
    assign s_axi_arready = q_r.arready;
    assign s_axi_rvalid = q_r.rvalid;
    assign s_axi_rdata = q_r.rdata;
    assign s_axi_rresp = q_r.rresp;
    assign sdo = q_r.sdo;
    assign irq = q_r.irq;

    a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        (q_r.ctrl2 & ~serial_ctl2_pkg::ctrl2_mask) == 32'h0)
        else $error("reserved control bits set");
    a_lock_while_on: assert property (@(posedge clk) disable iff (rst)
        q_r.on && $past(q_r.on) |-> $stable(q_r.ctrl2 & serial_ctl2_pkg::ctrl2_locked))
        else $error("locked field changed while on");
    a_rov_halt: assert property (@(posedge clk) disable iff (rst)
        word_done && q_r.rx_full && !q_r.ctrl2[serial_ctl2_pkg::ign_rov_bit] |=> q_r.halted)
        else $error("overflow did not halt");
    a_rov_keep: assert property (@(posedge clk) disable iff (rst)
        word_done && q_r.rx_full |=> $stable(q_r.rx_hold))
        else $error("held rx word overwritten");
    a_rov_event: assert property (@(posedge clk) disable iff (rst)
        word_done && q_r.rx_full && q_r.ctrl2[serial_ctl2_pkg::rov_en_bit]
        |=> q_r.status[1])
        else $error("overflow event missing");
    a_frm_noevent: assert property (@(posedge clk) disable iff (rst)
        !q_r.status[0] && !q_r.ctrl2[serial_ctl2_pkg::frm_en_bit] |=> !q_r.status[0])
        else $error("frame event while disabled");
    a_tur_halt: assert property (@(posedge clk) disable iff (rst)
        sck_fall && frm_edge && q_r.on && !q_r.halted && !q_r.tx_full && !mono &&
        !q_r.ctrl2[serial_ctl2_pkg::ign_tur_bit] |=> q_r.halted)
        else $error("underrun did not halt");
    a_tur_zero: assert property (@(posedge clk) disable iff (rst)
        sck_fall && frm_edge && q_r.on && !q_r.halted && !q_r.tx_full && !mono
        |=> q_r.tx_sh == '0)
        else $error("underrun not zero filled");
    a_irq_level: assert property (@(posedge clk) disable iff (rst)
        q_r.irq == |(q_r.status & q_r.mask))
        else $error("irq level wrong");
    // error events and halting
    a_frm_event: assert property (@(posedge clk) disable iff (rst)
        frm_err && q_r.ctrl2[serial_ctl2_pkg::frm_en_bit] |=> q_r.status[0])
        else $error("frame event missing");
    a_rov_noevent: assert property (@(posedge clk) disable iff (rst)
        !q_r.status[1] && !q_r.ctrl2[serial_ctl2_pkg::rov_en_bit] |=> !q_r.status[1])
        else $error("overflow event while disabled");
    a_tur_event: assert property (@(posedge clk) disable iff (rst)
        sck_fall && frm_edge && q_r.on && !q_r.halted && !q_r.tx_full &&
        q_r.ctrl2[serial_ctl2_pkg::tur_en_bit] |=> q_r.status[2])
        else $error("underrun event missing");
    a_tur_noevent: assert property (@(posedge clk) disable iff (rst)
        !q_r.status[2] && !q_r.ctrl2[serial_ctl2_pkg::tur_en_bit] |=> !q_r.status[2])
        else $error("underrun event while disabled");
    a_halt_freeze: assert property (@(posedge clk) disable iff (rst)
        q_r.halted |=> $stable(q_r.rx_sh) && $stable(q_r.tx_sh))
        else $error("shifting while halted");
    // receive word widening
    a_rx_sign_fill: assert property (@(posedge clk) disable iff (rst)
        s_axi_arvalid && q_r.arready && s_axi_araddr == serial_ctl2_pkg::rxdata_addr &&
        q_r.ctrl2[serial_ctl2_pkg::sign_ext_bit]
        |=> q_r.rdata[31:width] == {(32 - width){q_r.rdata[width-1]}})
        else $error("rx word not sign extended");
    a_rx_zero_fill: assert property (@(posedge clk) disable iff (rst)
        s_axi_arvalid && q_r.arready && s_axi_araddr == serial_ctl2_pkg::rxdata_addr &&
        !q_r.ctrl2[serial_ctl2_pkg::sign_ext_bit] |=> q_r.rdata[31:width] == '0)
        else $error("rx word not zero filled");
    // slot framing and control register reset
    a_plain_lead: assert property (@(posedge clk) disable iff (rst)
        sck_fall && frm_edge && q_r.on && !q_r.halted && !aud && q_r.tx_full
        |=> q_r.sdo == $past(q_r.tx_buf[width-1]))
        else $error("plain serial word did not start at once");
    a_i2s_lead: assert property (@(posedge clk) disable iff (rst)
        sck_fall && frm_edge && q_r.on && !q_r.halted && aud &&
        amode == serial_ctl2_pkg::mode_i2s |=> !q_r.sdo)
        else $error("i2s slot did not open with a delay bit");
    a_mono_hold: assert property (@(posedge clk) disable iff (rst)
        sck_fall && frm_edge && q_r.on && !q_r.halted && mono && !q_r.frm_s[1] &&
        q_r.tx_full |=> q_r.tx_full)
        else $error("mono left slot consumed the word");
    a_ctrl2_reset: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> q_r.ctrl2 == serial_ctl2_pkg::ctrl2_reset)
        else $error("control register not cleared by reset");
    c_write_ctrl2: cover property (@(posedge clk) q_r.aw_got && q_r.w_got &&
        q_r.awaddr == serial_ctl2_pkg::ctrl2_addr);
    c_rx_word: cover property (@(posedge clk) word_done && !q_r.rx_full);
    c_overflow: cover property (@(posedge clk) word_done && q_r.rx_full);
    c_irq: cover property (@(posedge clk) q_r.irq);
    c_mono_right: cover property (@(posedge clk) mono && q_r.right_slot && sck_fall);
endmodule
`default_nettype wire

/* rtl/serial_ctl2_pkg.sv */
// constants for the audio/error control block
package serial_ctl2_pkg;
    localparam logic [7:0] ctrl1_addr = 8'h00;
    localparam logic [7:0] ctrl2_addr = 8'h04;
    localparam logic [7:0] status_addr = 8'h08;
    localparam logic [7:0] mask_addr = 8'h0c;
    localparam logic [7:0] rxdata_addr = 8'h10;
    localparam logic [7:0] txdata_addr = 8'h14;
    localparam int sign_ext_bit = 15;
    localparam int frm_en_bit = 12;
    localparam int rov_en_bit = 11;
    localparam int tur_en_bit = 10;
    localparam int ign_rov_bit = 9;
    localparam int ign_tur_bit = 8;
    localparam int aud_en_bit = 7;
    localparam int mono_bit = 3;
    localparam int mod_lo_bit = 0;
    localparam int on_bit = 0;
    localparam logic [31:0] ctrl2_mask = 32'h0000_9f8b;
    localparam logic [31:0] ctrl2_locked = 32'h0000_008b;
    localparam logic [31:0] ctrl2_reset = 32'h0000_0000;
    localparam logic [2:0] irq_bits = 3'h7;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    localparam logic [1:0] mode_i2s = 2'h0;
    localparam logic [1:0] mode_left = 2'h1;
    localparam logic [1:0] mode_right = 2'h2;
    localparam logic [1:0] mode_pcm = 2'h3;
endpackage

/* sim/serial_peer.sv */
// behavioural codec on the far side of the serial link
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
    parameter int half_ns = 80
) (
    output logic sck, // bit clock, stands high between words
    output logic frame, // word select, toggles at the fall that opens a word
    output logic sdi, // data towards the block
    input wire logic sdo // data from the block
);
    logic [15:0] got;

    initial begin
        sck = 1'b1;
        frame = 1'b0;
        sdi = 1'b1;
        got = 16'h0;
    end

    // one word, msb first; gap keeps the clock stopped for a slow answer
    task automatic xfer(input logic [15:0] w, input int nbits, input int gap);
        #(gap * half_ns + 5);
        frame = ~frame;
        for (int i = nbits - 1; i >= 0; i--) begin
            sck = 1'b0;
            sdi = w[i];
            #half_ns;
            sck = 1'b1;
            #half_ns;
            got = {got[14:0], sdo};
        end
        // released line must not keep showing the last bit
        sdi = ~sdi;
    endtask
endmodule
`default_nettype wire

/* sim/serial_ctl2_tb.sv */
// self-checking bench for the audio/error control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
    begin \
        num_checks++; \
        if ((g) !== (e)) begin \
            bad_count++; \
            $display("MISMATCH at %0t got %h exp %h", $time, (g), (e)); \
        end \
    end
module serial_ctl2_tb;
    localparam logic [7:0] c1 = serial_ctl2_pkg::ctrl1_addr, c2 = serial_ctl2_pkg::ctrl2_addr,
        st = serial_ctl2_pkg::status_addr, mk = serial_ctl2_pkg::mask_addr,
        rx = serial_ctl2_pkg::rxdata_addr, tx = serial_ctl2_pkg::txdata_addr;
    localparam logic [31:0] sx = 32'h8000, fe = 32'h1000, ro = 32'h0800, tu = 32'h0400,
        ir = 32'h0200, it = 32'h0100, ae = 32'h0080, mo = 32'h0008;
    logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, sck, frame, sdi, sdo, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r, wresp;
    int bad_count, num_checks;

    serial_ctl2 i_serial_ctl2 (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .sck(sck), .frame(frame), .sdi(sdi), .sdo(sdo), .irq(irq));
    serial_peer i_serial_peer (.sck(sck), .frame(frame), .sdi(sdi), .sdo(sdo));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        wresp = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a, v, r);
        `CHK(v, e)
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #200us;
        bad_count++;
        stop_test();
    end

    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rc(c2, 32'h0);
        wr(c2, 32'hffff_ffff);
        `CHK(wresp, serial_ctl2_pkg::resp_okay)
        rc(c2, serial_ctl2_pkg::ctrl2_mask);
        wr(c2, 32'h0);
        wstrb <= 4'h2;
        wr(c2, 32'hffff_ffff);
        wstrb <= 4'hf;
        rc(c2, 32'h0000_9f00);
        rd(8'h20, v, r);
        `CHK(r, serial_ctl2_pkg::resp_slverr)
        `CHK(v, 32'h0)
        wr(8'h20, 32'h0);
        `CHK(wresp, serial_ctl2_pkg::resp_slverr)
        for (int m = 0; m < 4; m++) begin
            wr(c2, ae | 32'(m));
            rc(c2, ae | 32'(m));
        end
        wr(c1, 32'h1);
        wr(c2, 32'h0);
        rc(c2, ae | 32'h3);
        wr(c1, 32'h0);
        wr(c2, sx | it);
        wr(mk, 32'h7);
        wr(c1, 32'h1);
        i_serial_peer.xfer(16'h8001, 16, 0);
        rc(rx, 32'hffff_8001);
        wr(c2, it);
        i_serial_peer.xfer(16'h8001, 16, 3);
        rc(rx, 32'h0000_8001);
        wr(c2, ir | it | ro);
        i_serial_peer.xfer(16'h1111, 16, 0);
        i_serial_peer.xfer(16'h2222, 16, 0);
        rc(st, 32'h2);
        `CHK(irq, 1'b1)
        rc(rx, 32'h1111);
        rc(c1, 32'h1);
        wr(mk, 32'h0);
        rc(st, 32'h2);
        `CHK(irq, 1'b0)
        wr(mk, 32'h7);
        wr(st, 32'h2);
        rc(st, 32'h0);
        `CHK(irq, 1'b0)
        wr(c2, it);
        i_serial_peer.xfer(16'h3333, 16, 0);
        i_serial_peer.xfer(16'h4444, 16, 0);
        rc(st, 32'h0);
        rc(c1, 32'h3);
        wr(c1, 32'h0);
        rd(rx, v, r);
        wr(c2, tu | it | ir | mo);
        wr(c1, 32'h1);
        i_serial_peer.xfer(16'h0, 16, 0);
        `CHK(i_serial_peer.got, 16'h0)
        rc(st, 32'h4);
        wr(tx, 32'ha5c3);
        i_serial_peer.xfer(16'h0, 16, 0);
        `CHK(i_serial_peer.got, 16'ha5c3)
        i_serial_peer.xfer(16'h0, 16, 0);
        `CHK(i_serial_peer.got, 16'h0)
        rc(c1, 32'h1);
        wr(c2, tu | ir);
        i_serial_peer.xfer(16'h0, 16, 0);
        rc(c1, 32'h3);
        wr(c1, 32'h0);
        wr(st, 32'h7);
        wr(c2, ae | mo | fe | ir | it | 32'h1);
        wr(c1, 32'h1);
        // one empty right slot so that the word below opens on a left slot
        i_serial_peer.xfer(16'h0, 16, 0);
        wr(tx, 32'h1234);
        i_serial_peer.xfer(16'h0, 16, 0);
        `CHK(i_serial_peer.got, 16'h1234)
        i_serial_peer.xfer(16'h0, 16, 2);
        `CHK(i_serial_peer.got, 16'h1234)
        i_serial_peer.xfer(16'h0, 5, 0);
        i_serial_peer.xfer(16'h0, 16, 0);
        rc(st, 32'h1);
        wr(c1, 32'h0);
        wr(c2, ae | ir | it);
        wr(c1, 32'h1);
        wr(tx, 32'h1234);
        i_serial_peer.xfer(16'h0, 16, 0);
        `CHK(i_serial_peer.got, 16'h091a)
        stop_test();
    end
endmodule
`default_nettype wire
